// ==== core/assp_defines.svh ====
/*
 * Constants of the accelerometer serial slave port: register offsets,
 * field positions, reset values and command byte layout.
 * Assumes inclusion by bare name from the core files.
 */
`ifndef ASSP_DEFINES_SVH
`define ASSP_DEFINES_SVH

`define ASSP_ADDR_W 6
`define ASSP_OFS_FORMAT 6'h31
`define ASSP_FORMAT_RST 8'h00
`define ASSP_FORMAT_WIRE_BIT 6
`define ASSP_CMD_RD_BIT 7
`define ASSP_CMD_BURST_BIT 6
`define ASSP_BYTE_BITS 4'h8

`endif

// ==== core/assp_pkg.sv ====
/*
 * Types shared by the serial slave port.
 * Assumes assp_defines.svh is visible to the including files.
 */
`default_nettype none
package assp_pkg;
    typedef enum logic [1:0] {
        ASSP_IDLE = 2'b00,
        ASSP_CMD  = 2'b01,
        ASSP_WR   = 2'b10,
        ASSP_RD   = 2'b11
    } assp_state_t;
endpackage : assp_pkg
`default_nettype wire

// ==== core/assp_sync.sv ====
/*
 * Two-flip-flop synchroniser for a vector of pin levels.
 * Assumes the pins are asynchronous to i_core_clk.
 */
`default_nettype none
module assp_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // The first stage feeds only the second one.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= RST;
            sync_q <= RST;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : assp_sync
`default_nettype wire

// ==== core/assp_port.sv ====
/*
 * Serial slave port of a 3-axis accelerometer, SPI mode only.
 * Assumes the pins are asynchronous and sampled by a much faster
 * i_core_clk; the register file lives outside apart from the format
 * register, which this block holds.
 */
`include "assp_defines.svh"
`default_nettype none
module assp_port #(
    parameter int ADDR_W = `ASSP_ADDR_W
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Serial pins
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic o_sdio,
    output logic o_sdio_oe,
    // Register side
    output logic [ADDR_W-1:0] o_reg_addr,
    output logic o_reg_wr,
    output logic [7:0] o_reg_wdata,
    output logic o_reg_rd,
    input wire logic [7:0] i_reg_rdata,
    // Status
    output logic o_two_wire_mode,
    output logic o_three_wire
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pins_s;
    logic cs_s;
    logic sclk_s;
    logic sdi_s;

    // Reset values match idle pins: deselected, clock high, data high.
    // Any other select or clock value would fake a select or a clock edge after reset.
    assp_sync #(.W(3), .RST(3'h7)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_cs_n, i_sclk, i_sdi}),
        .o_sync(pins_s)
    );
    assign cs_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdi_s = pins_s[0];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    assp_pkg::assp_state_t st_q, st_d;
    logic sclk_q, sclk_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] tx_q, tx_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic burst_flag_q, burst_flag_d;
    logic [7:0] fmt_q, fmt_d;
    logic sdo_q, sdo_d;
    logic sdo_oe_q, sdo_oe_d;
    logic sdio_oe_q, sdio_oe_d;
    logic wr_q, wr_d;
    logic rd_q, rd_d;
    logic [7:0] wdata_q, wdata_d;
    logic [ADDR_W-1:0] radr_q, radr_d;
    logic two_q, two_d;
    logic cs_seen_q, cs_seen_d;
    logic load_q, load_d;

    logic rise;
    logic fall;
    logic [7:0] nxt_byte;
    logic [7:0] rdsrc;

    assign rise = sclk_s & ~sclk_q;
    assign fall = ~sclk_s & sclk_q;
    assign nxt_byte = {sh_q[6:0], sdi_s};
    // The format register answers locally; all others come from outside.
    assign rdsrc = (addr_q == `ASSP_OFS_FORMAT) ? fmt_q : i_reg_rdata;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        sclk_d = sclk_s;
        bit_d = bit_q;
        sh_d = sh_q;
        tx_d = tx_q;
        addr_d = addr_q;
        burst_flag_d = burst_flag_q;
        fmt_d = fmt_q;
        sdo_d = sdo_q;
        sdo_oe_d = sdo_oe_q;
        sdio_oe_d = sdio_oe_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        wdata_d = wdata_q;
        radr_d = radr_q;
        two_d = two_q;
        cs_seen_d = cs_seen_q;
        load_d = 1'b0;
        // Chip select never seen low means two-wire mode.
        if (!cs_s) begin
            cs_seen_d = 1'b1;
            two_d = 1'b0;
        end
        if (cs_s) begin
            // Deselect drops any partial byte and frees the data lines.
            st_d = assp_pkg::ASSP_IDLE;
            bit_d = 3'h0;
            sdo_oe_d = 1'b0;
            sdio_oe_d = 1'b0;
            two_d = ~cs_seen_q;
        end else begin
            if (st_q == assp_pkg::ASSP_IDLE) begin
                st_d = assp_pkg::ASSP_CMD;
                bit_d = 3'h0;
            end
            if (load_q) begin
                tx_d = rdsrc;
            end
            if (rise && st_q != assp_pkg::ASSP_IDLE) begin
                sh_d = nxt_byte;
                bit_d = bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    case (st_q)
                        assp_pkg::ASSP_CMD: begin
                            addr_d = nxt_byte[ADDR_W-1:0];
                            burst_flag_d =
                                nxt_byte[`ASSP_CMD_BURST_BIT];
                            if (nxt_byte[`ASSP_CMD_RD_BIT]) begin
                                st_d = assp_pkg::ASSP_RD;
                                rd_d = 1'b1;
                                radr_d = nxt_byte[ADDR_W-1:0];
                                load_d = 1'b1;
                            end else begin
                                st_d = assp_pkg::ASSP_WR;
                            end
                        end
                        assp_pkg::ASSP_WR: begin
                            wr_d = 1'b1;
                            wdata_d = nxt_byte;
                            radr_d = addr_q;
                            if (addr_q == `ASSP_OFS_FORMAT) begin
                                fmt_d = nxt_byte;
                            end
                            if (burst_flag_q) begin
                                addr_d = addr_q + ADDR_W'(1);
                            end
                        end
                        assp_pkg::ASSP_RD: begin
                            if (burst_flag_q) begin
                                addr_d = addr_q + ADDR_W'(1);
                                rd_d = 1'b1;
                                radr_d = addr_q + ADDR_W'(1);
                                load_d = 1'b1;
                            end
                        end
                        default: begin
                            st_d = assp_pkg::ASSP_IDLE;
                        end
                    endcase
                end
            end
            // Output changes on the falling edge; bit 7 goes first.
            if (fall && st_q == assp_pkg::ASSP_RD) begin
                sdo_d = tx_q[3'h7 - bit_q];
                if (fmt_q[`ASSP_FORMAT_WIRE_BIT]) begin
                    sdio_oe_d = 1'b1;
                    sdo_oe_d = 1'b0;
                end else begin
                    sdo_oe_d = 1'b1;
                    sdio_oe_d = 1'b0;
                end
            end
            // A write returns nothing useful; keep the lines quiet.
            if (st_q != assp_pkg::ASSP_RD) begin
                sdio_oe_d = 1'b0;
                sdo_d = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= assp_pkg::ASSP_IDLE;
            sclk_q <= 1'b1;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            addr_q <= '0;
            burst_flag_q <= 1'b0;
            fmt_q <= `ASSP_FORMAT_RST;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            sdio_oe_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            wdata_q <= 8'h00;
            radr_q <= '0;
            two_q <= 1'b1;
            cs_seen_q <= 1'b0;
            load_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sclk_q <= sclk_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            addr_q <= addr_d;
            burst_flag_q <= burst_flag_d;
            fmt_q <= fmt_d;
            sdo_q <= sdo_d;
            sdo_oe_q <= sdo_oe_d;
            sdio_oe_q <= sdio_oe_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            wdata_q <= wdata_d;
            radr_q <= radr_d;
            two_q <= two_d;
            cs_seen_q <= cs_seen_d;
            load_q <= load_d;
        end
    end

    assign o_sdo = sdo_q;
    assign o_sdo_oe = sdo_oe_q;
    assign o_sdio = sdo_q;
    assign o_sdio_oe = sdio_oe_q;
    assign o_reg_addr = radr_q;
    assign o_reg_wr = wr_q;
    assign o_reg_wdata = wdata_q;
    assign o_reg_rd = rd_q;
    assign o_two_wire_mode = two_q;
    assign o_three_wire = fmt_q[`ASSP_FORMAT_WIRE_BIT];
endmodule : assp_port
`default_nettype wire

// ==== testbench/assp_port_checker.sv ====
/* Checker for assp_port pins and register strobes.
   Assumes one core clock domain and a bind onto assp_port. */
`default_nettype none
module assp_port_checker #(
    parameter int ADDR_W = 6
) (
    // Watched ports
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic o_sdo,
    input wire logic o_sdo_oe,
    input wire logic o_sdio_oe,
    input wire logic [ADDR_W-1:0] o_reg_addr,
    input wire logic o_reg_wr,
    input wire logic [7:0] o_reg_wdata,
    input wire logic o_reg_rd,
    input wire logic o_two_wire_mode,
    input wire logic o_three_wire
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    a_oe_off_desel: assert property (
        i_cs_n [*5] |-> !o_sdo_oe && !o_sdio_oe) else $error("oe while idle");
    a_no_strobe_idle: assert property (
        i_cs_n [*6] |-> !o_reg_wr && !o_reg_rd) else $error("strobe idle");
    a_oe_one_line: assert property (
        !(o_sdo_oe && o_sdio_oe)) else $error("both lines driven");
    a_sdio_three: assert property (
        o_sdio_oe |-> o_three_wire) else $error("shared line in 4-wire");
    a_sdo_four: assert property (
        o_sdo_oe |-> !o_three_wire) else $error("sdo in 3-wire");
    a_wr_byte_gap: assert property (
        o_reg_wr |=> !o_reg_wr [*8]) else $error("write strobes too close");
    a_fmt_update: assert property (
        o_reg_wr && o_reg_addr == 6'h31 |-> ##[1:2]
        o_three_wire == o_reg_wdata[6]) else $error("format bit stale");
    a_two_wire_drop: assert property (
        $fell(i_cs_n) |-> ##[1:4] !o_two_wire_mode) else $error("mode flag");
    a_two_wire_stay: assert property (
        !o_two_wire_mode |=> !o_two_wire_mode) else $error("mode flag back");
    a_sdo_on_fall: assert property (
        o_sdo_oe && $past(o_sdo_oe) && !i_cs_n && $changed(o_sdo) |-> !i_sclk)
        else $error("sdo moved with clock high");
endmodule : assp_port_checker
bind assp_port assp_port_checker #(.ADDR_W(ADDR_W)) chk_u (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
    .i_sclk(i_sclk), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .o_sdio_oe(o_sdio_oe), .o_reg_addr(o_reg_addr), .o_reg_wr(o_reg_wr),
    .o_reg_wdata(o_reg_wdata), .o_reg_rd(o_reg_rd),
    .o_two_wire_mode(o_two_wire_mode), .o_three_wire(o_three_wire));
`default_nettype wire

// ==== testbench/assp_host_model.sv ====
/* Host model: serial master, polarity 1, phase 1, 125 ns link clock.
   Assumes the bench fills tx and reads rx by hierarchical name. */
`default_nettype none
module assp_host_model (
    // Pacing clock and returned data
    input wire logic i_core_clk,
    input wire logic i_miso,
    // Driven lines
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_mosi
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] tx [8];
    logic [7:0] rx [8];
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_mosi = 1'b1;
    end
    // A released line toggles so that a stale level never passes as data.
    // The link rate is fast enough for every output data rate.
    task automatic shift(input logic [7:0] v, input int k, input logic rel,
                         output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - k; i--) begin
            @(negedge i_core_clk);
            o_sclk = 1'b0;
            o_mosi = rel ? ~o_mosi : v[i];
            repeat (12) @(negedge i_core_clk);
            o_sclk = 1'b1;
            r[i] = i_miso;
            repeat (12) @(negedge i_core_clk);
        end
    endtask : shift
    task automatic xfer(input logic [7:0] cmd, input int n, input int cut);
        logic [7:0] d;
        @(negedge i_core_clk);
        o_cs_n = 1'b0;
        repeat (4) @(negedge i_core_clk);
        shift(cmd, 8, 1'b0, d);
        for (int j = 0; j < n; j++) begin
            shift(tx[j], 8, cmd[7], d);
            if (cmd[7]) rx[j] = d;
        end
        if (cut > 0) shift(8'hFF, cut, 1'b0, d);
        repeat (12) @(negedge i_core_clk);
        o_cs_n = 1'b1;
        repeat (40) @(negedge i_core_clk);
    endtask : xfer
endmodule : assp_host_model
`default_nettype wire

// ==== testbench/tb.sv ====
/* Bench for assp_port: host model on the pins, register array behind.
   Assumes a 200 MHz core clock and the host model's 125 ns link. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, sclk, mosi, sdi, miso, sdo, sdo_oe, sdio, sdio_oe;
    logic reg_wr, reg_rd, two_wire, three;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata = 8'h00;
    logic [7:0] regs [64];
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int n_wr = 0;
    int n_rd = 0;
    int nw;
    always #2.5 clk = ~clk;
    assign sdi = sdio_oe ? sdio : mosi;
    assign miso = three ? sdi : (sdo_oe ? sdo : ~sdo);
    assp_host_model host_u (.i_core_clk(clk), .i_miso(miso),
        .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
    assp_port dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
        .o_sdio(sdio), .o_sdio_oe(sdio_oe), .o_reg_addr(addr),
        .o_reg_wr(reg_wr), .o_reg_wdata(wdata), .o_reg_rd(reg_rd),
        .i_reg_rdata(rdata), .o_two_wire_mode(two_wire),
        .o_three_wire(three));
    always @(negedge clk) rdata <= regs[addr];
    always @(posedge clk) begin
        cyc++;
        if (reg_rd) begin
            n_rd++;
        end
        if (reg_wr) begin
            regs[addr] <= wdata;
            n_wr++;
        end
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk({7'h00, two_wire}, 8'h01);
        chk({5'h00, sdo_oe, sdio_oe, three}, 8'h00);
        host_u.tx[0] = 8'hA5;
        host_u.xfer(8'h10, 1, 0);
        chk(regs[16], 8'hA5);
        chk({7'h00, two_wire}, 8'h00);
        for (int j = 0; j < 3; j++) begin
            host_u.tx[j] = 8'(8'h11 * (j + 1));
        end
        host_u.xfer(8'h60, 3, 0);
        for (int j = 0; j < 3; j++) begin
            chk(regs[32 + j], 8'(8'h11 * (j + 1)));
        end
        // Both wirings: format bit clear, then set.
        for (int w = 0; w < 2; w++) begin
            host_u.tx[0] = {1'b0, w[0], 6'h00};
            host_u.xfer(8'h31, 1, 0);
            chk({7'h00, three}, 8'(w));
            host_u.xfer(8'hB1, 1, 0);
            chk(host_u.rx[0], {1'b0, w[0], 6'h00});
            host_u.xfer(8'hE0, 3, 0);
            for (int j = 0; j < 3; j++) begin
                chk(host_u.rx[j], 8'(8'h11 * (j + 1)));
            end
            nw = n_rd;
            host_u.xfer(8'h90, 2, 0);
            chk(host_u.rx[1], 8'hA5);
            chk(8'(n_rd - nw), 8'h01);
        end
        nw = n_wr;
        host_u.tx[0] = 8'h77;
        host_u.xfer(8'h15, 0, 5);
        chk(8'(n_wr - nw), 8'h00);
        host_u.tx[0] = 8'h3C;
        host_u.xfer(8'h15, 1, 0);
        chk(regs[21], 8'h3C);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
